/* include/ihc_defines.svh */
// register offsets, field positions and reset values
// assumes inclusion by bare name from the design file
`ifndef IHC_DEFINES_SVH
`define IHC_DEFINES_SVH

`define IHC_ADDR_RELOAD 12'h000
`define IHC_ADDR_DATA 12'h004
`define IHC_ADDR_CTRL_ONE 12'h008
`define IHC_ADDR_CTRL_TWO 12'h00C
`define IHC_ADDR_CTRL_THREE 12'h010
`define IHC_ADDR_MASK 12'h014
`define IHC_ADDR_STATUS 12'h018
`define IHC_ADDR_IRQ_STATUS 12'h01C
`define IHC_ADDR_IRQ_MASK 12'h020

// control one
`define IHC_C1_ENABLE 5
// control two
`define IHC_C2_STOP 2
`define IHC_C2_RESTART 1
// status
`define IHC_ST_STOP_SEEN 4
`define IHC_ST_START_SEEN 3
// interrupt status / mask
`define IHC_IRQ_COLLISION 0
`define IHC_IRQ_DONE 1

`define IHC_RELOAD_RESET 8'h00
`define IHC_CTRL_RESET 8'h00

`endif

/* include/ihc_pkg.sv */
// types used by the collision block
// assumes nothing beyond a SystemVerilog compiler
package ihc_pkg;
  typedef enum logic [3:0] {
    IHC_IDLE,
    IHC_RS_WAIT,
    IHC_RS_SCL_HI,
    IHC_RS_HOLD,
    IHC_RS_FINAL,
    IHC_SP_SDA_LO,
    IHC_SP_SCL_HI,
    IHC_SP_COUNT,
    IHC_SP_SDA_HI
  } ihc_state_t;
  typedef logic [7:0] ihc_byte_t;
endpackage

/* hw/ihc_host_collision.sv */
// i2c host repeated start / stop generator with collision detection,
// apb register file and one level interrupt
// assumes open-drain sda/scl resolved outside; pins are asynchronous
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defines.svh"

module ihc_host_collision (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  output logic irq
);
  import ihc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;
  logic scl_prev_reg;
  logic sda, scl, scl_fall;

  // reset to the pulled-up idle level so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sda_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_sync_reg <= 2'b11;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
    end
  end

  // scl history, fed only from the second sync stage
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
    end
  end

  assign sda = sda_sync_reg[1];
  assign scl = scl_sync_reg[1];
  assign scl_fall = scl_prev_reg & ~scl;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ihc_byte_t reload_reg;
  ihc_byte_t data_reg;
  ihc_byte_t ctrl_one_reg;
  ihc_byte_t ctrl_three_reg;
  ihc_byte_t addr_mask_reg;
  ihc_byte_t irq_mask_reg;
  ihc_byte_t irq_status_reg;
  logic restart_request_reg;
  logic stop_request_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  ihc_state_t state_reg;
  ihc_byte_t count_reg;

  logic wr_en, rd_en, enabled, collision, done, count_zero;
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & pready;
  assign enabled = ctrl_one_reg[`IHC_C1_ENABLE];
  assign count_zero = (count_reg == 8'h00);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reload_reg <= `IHC_RELOAD_RESET;
      data_reg <= `IHC_CTRL_RESET;
      ctrl_one_reg <= `IHC_CTRL_RESET;
      ctrl_three_reg <= `IHC_CTRL_RESET;
      addr_mask_reg <= `IHC_CTRL_RESET;
      irq_mask_reg <= `IHC_CTRL_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        `IHC_ADDR_RELOAD: reload_reg <= pwdata[7:0];
        // data byte is only stored and read back over apb, never sent or received
        `IHC_ADDR_DATA: data_reg <= pwdata[7:0];
        `IHC_ADDR_CTRL_ONE: ctrl_one_reg <= pwdata[7:0];
        `IHC_ADDR_CTRL_THREE: ctrl_three_reg <= pwdata[7:0];
        `IHC_ADDR_MASK: addr_mask_reg <= pwdata[7:0];
        `IHC_ADDR_IRQ_MASK: irq_mask_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request bits: software sets, hardware clears on done or abort
  // ----------------------------------------------------------------
  logic ctrl_two_wr;
  assign ctrl_two_wr = wr_en & (paddr == `IHC_ADDR_CTRL_TWO);

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !enabled) begin
      restart_request_reg <= 1'b0;
      stop_request_reg <= 1'b0;
    end else if (collision || done) begin
      restart_request_reg <= 1'b0;
      stop_request_reg <= 1'b0;
    end else if (ctrl_two_wr && state_reg == IHC_IDLE) begin
      restart_request_reg <= pwdata[`IHC_C2_RESTART];
      stop_request_reg <= pwdata[`IHC_C2_STOP] & ~pwdata[`IHC_C2_RESTART];
    end
  end

  // ----------------------------------------------------------------
  // condition sequencer and bit-period counter
  // ----------------------------------------------------------------
  logic sda_drive_low_reg, scl_drive_low_reg;

  always_comb begin
    collision = 1'b0;
    if (enabled) begin
      unique case (state_reg)
        IHC_RS_SCL_HI: collision = scl && !sda;
        IHC_RS_HOLD: collision = scl_fall;
        IHC_SP_SCL_HI: collision = 1'b0;
        IHC_SP_COUNT: collision = !scl;
        IHC_SP_SDA_HI: collision = count_zero && !sda;
        default: collision = 1'b0;
      endcase
    end
  end

  assign done = (state_reg == IHC_RS_FINAL && count_zero) ||
                (state_reg == IHC_SP_SDA_HI && count_zero && sda);

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !enabled) begin
      state_reg <= IHC_IDLE;
      count_reg <= 8'h00;
      sda_drive_low_reg <= 1'b0;
      scl_drive_low_reg <= 1'b0;
    end else if (collision) begin
      state_reg <= IHC_IDLE;
      sda_drive_low_reg <= 1'b0;
      scl_drive_low_reg <= 1'b0;
      count_reg <= 8'h00;
    end else begin
      if (!count_zero) count_reg <= count_reg - 8'h01;
      unique case (state_reg)
        IHC_IDLE: begin
          if (restart_request_reg) begin
            sda_drive_low_reg <= 1'b0;
            scl_drive_low_reg <= 1'b1;
            count_reg <= reload_reg;
            state_reg <= IHC_RS_WAIT;
          end else if (stop_request_reg) begin
            sda_drive_low_reg <= 1'b1;
            scl_drive_low_reg <= 1'b1;
            state_reg <= IHC_SP_SDA_LO;
          end
        end
        IHC_RS_WAIT: begin
          if (count_zero) begin
            scl_drive_low_reg <= 1'b0;
            state_reg <= IHC_RS_SCL_HI;
          end
        end
        IHC_RS_SCL_HI: begin
          if (scl) begin
            count_reg <= reload_reg;
            state_reg <= IHC_RS_HOLD;
          end
        end
        IHC_RS_HOLD: begin
          // sda may fall here from another host; not a collision
          if (count_zero && scl && sda) begin
            sda_drive_low_reg <= 1'b1;
            count_reg <= reload_reg;
            state_reg <= IHC_RS_FINAL;
          end else if (count_zero) begin
            // sda already low from an earlier start; drive sda low and go on to the final hold
            count_reg <= reload_reg;
            sda_drive_low_reg <= 1'b1;
            state_reg <= IHC_RS_FINAL;
          end
        end
        IHC_RS_FINAL: begin
          if (count_zero) begin
            scl_drive_low_reg <= 1'b1;
            state_reg <= IHC_IDLE;
          end
        end
        IHC_SP_SDA_LO: begin
          if (!sda) begin
            scl_drive_low_reg <= 1'b0;
            state_reg <= IHC_SP_SCL_HI;
          end
        end
        IHC_SP_SCL_HI: begin
          // clock stretching: wait for scl to really read high
          if (scl) begin
            count_reg <= reload_reg;
            state_reg <= IHC_SP_COUNT;
          end
        end
        IHC_SP_COUNT: begin
          if (count_zero) begin
            sda_drive_low_reg <= 1'b0;
            count_reg <= reload_reg;
            state_reg <= IHC_SP_SDA_HI;
          end
        end
        IHC_SP_SDA_HI: begin
          if (count_zero) state_reg <= IHC_IDLE;
        end
        default: state_reg <= IHC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus condition monitor for start / stop seen bits
  // ----------------------------------------------------------------
  logic sda_prev_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !enabled) begin
      sda_prev_reg <= 1'b1;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else begin
      sda_prev_reg <= sda;
      if (scl && scl_prev_reg && sda_prev_reg && !sda) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg <= 1'b0;
      end else if (scl && scl_prev_reg && !sda_prev_reg && sda) begin
        stop_seen_reg <= 1'b1;
        start_seen_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, cleared by read, set beats clear
  // ----------------------------------------------------------------
  ihc_byte_t irq_set;
  ihc_byte_t irq_status_next;
  logic irq_rd;
  assign irq_rd = rd_en & (paddr == `IHC_ADDR_IRQ_STATUS);

  always_comb begin
    irq_set = 8'h00;
    irq_set[`IHC_IRQ_COLLISION] = collision;
    irq_set[`IHC_IRQ_DONE] = done;
  end

  // a read clears, but an event in the same cycle still lands
  assign irq_status_next = irq_rd ? irq_set : (irq_status_reg | irq_set);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_status_reg <= 8'h00;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // fed from the next status so the level tracks the sticky bits
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // pin drivers: open drain, oe high only while pulling low
  // ----------------------------------------------------------------
  // collision lets go in the same cycle as the abort, not one later
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= sda_drive_low_reg & enabled & ~collision;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_oe <= 1'b0;
    end else begin
      scl_oe <= scl_drive_low_reg & enabled & ~collision;
    end
  end

  // open drain: the data value stays low, only the enables move
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb read path, one wait state so pready comes from a flop
  // ----------------------------------------------------------------
  ihc_byte_t rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (paddr)
      `IHC_ADDR_RELOAD: rd_byte = reload_reg;
      `IHC_ADDR_DATA: rd_byte = data_reg;
      `IHC_ADDR_CTRL_ONE: rd_byte = ctrl_one_reg;
      `IHC_ADDR_CTRL_TWO: begin
        rd_byte[`IHC_C2_STOP] = stop_request_reg;
        rd_byte[`IHC_C2_RESTART] = restart_request_reg;
      end
      `IHC_ADDR_CTRL_THREE: rd_byte = ctrl_three_reg;
      `IHC_ADDR_MASK: rd_byte = addr_mask_reg;
      `IHC_ADDR_STATUS: begin
        rd_byte[`IHC_ST_STOP_SEEN] = stop_seen_reg;
        rd_byte[`IHC_ST_START_SEEN] = start_seen_reg;
      end
      `IHC_ADDR_IRQ_STATUS: rd_byte = irq_status_reg;
      `IHC_ADDR_IRQ_MASK: rd_byte = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      prdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule

`default_nettype wire

/* sim/ihc_bus_model.sv */
// other hosts and clients sharing the open-drain sda/scl pair
// assumes host oe pulls low; both lines have pull-ups
`timescale 1ns/1ps
`default_nettype none
module ihc_bus_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic hold_sda,
  input wire logic hold_scl,
  input wire logic [7:0] stretch_len,
  output logic sda_line,
  output logic scl_line
);
  logic [7:0] stretch_cnt = 8'h00;
  logic scl_oe_d = 1'b0;
  logic stretching;
  // slow client holds scl low after the host lets go
  always @(posedge ref_clk) begin
    scl_oe_d <= scl_oe;
    if (scl_oe_d && !scl_oe)
      stretch_cnt <= stretch_len;
    else if (stretch_cnt != 8'h00)
      stretch_cnt <= stretch_cnt - 8'h01;
  end
  // no one-cycle high glitch before the stretch counter loads
  assign stretching = stretch_cnt != 8'h00 ||
    (scl_oe_d && !scl_oe && stretch_len != 8'h00);
  assign sda_line = !(sda_oe || hold_sda);
  assign scl_line = !(scl_oe || hold_scl || stretching);
endmodule
`default_nettype wire

/* sim/ihc_host_collision_asserts.sv */
// port checks for the collision block
// assumes one domain, ref_clk, synchronous active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module ihc_host_collision_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_ready_access: assert property (psel && penable && !pready |=> pready)
    else $error("no answer to access");
  chk_unmapped_err: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped without error");
  chk_mapped_ok: assert property (pready && paddr <= 12'h020 &&
    paddr[1:0] == 2'b00 |-> !pslverr && prdata[31:8] == 24'h00_0000)
    else $error("mapped access bad");
  chk_open_drain: assert property (!sda_out && !scl_out)
    else $error("pin driven high");
  chk_rs_scl_high: assert property ($rose(sda_oe) && !scl_oe |->
    $past(scl_in, 4) && $past(scl_in, 5))
    else $error("sda driven after scl low");
  chk_rs_sda_hold: assert property ($rose(scl_oe) && $past(sda_oe) |->
    $past(sda_oe, 2) && $past(sda_oe, 3))
    else $error("final count too short");
  chk_stop_count: assert property ($fell(sda_oe) && !scl_oe && scl_in |->
    $past(scl_in, 4) && $past(scl_in, 5))
    else $error("sda freed before count");
endmodule
bind ihc_host_collision ihc_host_collision_asserts chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe)
);
`default_nettype wire

/* sim/ihc_host_collision_tb_top.sv */
// bench: apb register access, restart and stop with collisions
// assumes the bus model resolves both lines from all pull-downs
`timescale 1ns/1ps
`default_nettype none
module ihc_host_collision_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, sda_in, sda_out, sda_oe, scl_in, scl_out, scl_oe;
  logic irq, rd_err;
  logic hold_sda = 1'b0;
  logic hold_scl = 1'b0;
  logic [7:0] stretch_len = 8'h00;
  int mismatches = 0;
  int checks = 0;
  ihc_host_collision dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
  ihc_bus_model bus_u (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .scl_oe(scl_oe),
    .hold_sda(hold_sda), .hold_scl(hold_scl), .stretch_len(stretch_len),
    .sda_line(sda_in), .scl_line(scl_in));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_oe(input logic on_sda, input logic v);
    int n;
    n = 0;
    while ((on_sda ? sda_oe : scl_oe) !== v && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if ((on_sda ? sda_oe : scl_oe) !== v) mismatches++;
  endtask
  // ev: 1 sda low from start, 2 sda pulse in count,
  // 3 other host clocks scl, 4 sda low after release
  task automatic cond(input logic [31:0] cmd, input int ev,
                      input logic [31:0] exp);
    int n;
    n = 0;
    if (ev == 1) hold_sda <= 1'b1;
    apb(1'b1, 12'h00C, cmd);
    if (ev >= 2) begin
      wait_oe(ev == 4, 1'b1);
      wait_oe(ev == 4, 1'b0);
      repeat (ev == 4 ? 0 : 5) @(posedge ref_clk);
      if (ev == 3) begin
        for (int i = 0; i < 4; i++) begin
          hold_scl <= ~hold_scl;
          repeat (4) @(posedge ref_clk);
        end
      end else begin
        hold_sda <= 1'b1;
        repeat (2) @(posedge ref_clk);
        if (ev == 2) hold_sda <= 1'b0;
      end
    end
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (irq !== 1'b1) mismatches++;
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd_data, exp);
    chk({30'h0, sda_oe, scl_oe}, (cmd == 2 && exp == 2) ? 32'h3 : 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd_data, 32'h0);
    hold_sda <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h004, 32'hA5);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd_data, 32'h8);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd_data, 32'hA5);
    apb(1'b1, 12'h020, 32'h3);
    apb(1'b1, 12'h008, 32'h20);
    cond(32'h2, 0, 32'h2);
    cond(32'h2, 2, 32'h2);
    cond(32'h2, 3, 32'h1);
    cond(32'h2, 1, 32'h1);
    stretch_len <= 8'h14;
    cond(32'h4, 0, 32'h2);
    stretch_len <= 8'h00;
    cond(32'h4, 3, 32'h1);
    cond(32'h4, 4, 32'h1);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b1, 12'h00C, 32'h4);
    repeat (200) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h020, 32'h3);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd_data, 32'h2);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    chk({30'h0, sda_out, scl_out}, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd_data, 32'h10);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd_data, 32'h0);
    chk({30'h0, sda_oe, scl_oe}, 32'h0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
